/* rtl/lpps_pkg.sv */
package lpps_pkg;

	// ****************************************
	// power states
	// ****************************************
	typedef enum logic [2:0] {
		PST_POR,
		PST_RSTIN,
		PST_IRST,
		PST_RUN,
		PST_STOP,
		PST_DSTB,
		PST_DRET
	} lpps_pstate_t;

	// ****************************************
	// pin function groups
	// ****************************************
	typedef enum logic [2:0] {
		FN_GPIO,
		FN_PERIPH,
		FN_XTAL_OUT,
		FN_ANALOG,
		FN_WAKEUP,
		FN_EXTINT,
		FN_LOCKED
	} lpps_func_t;

	localparam int           LPPS_NPINS     = 8;
	localparam logic [31:0]  LPPS_PIN_FUNC  = 32'h0000_0000;
	localparam logic [31:0]  LPPS_PIN_FALLB = 32'h0000_0000;

	// ****************************************
	// apb register map
	// ****************************************
	localparam logic [11:0] LPPS_OFF_CTRL   = 12'h000;
	localparam logic [11:0] LPPS_OFF_FUNC   = 12'h004;
	localparam logic [11:0] LPPS_OFF_FALLB  = 12'h008;
	localparam logic [11:0] LPPS_OFF_STATUS = 12'h00c;
	localparam logic [11:0] LPPS_OFF_FUNC_B = 12'h010;
	localparam int          LPPS_CTRL_LEVEL = 0;
	localparam int          LPPS_CTRL_OSCST = 1;
	localparam logic [31:0] LPPS_RST_ZERO   = 32'h0000_0000;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} lpps_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} lpps_apb_rsp_t;

endpackage

/* rtl/lpps_ctrl.sv */
`timescale 1ns/10ps
module lpps_ctrl #(
	parameter int NPINS = 8
) (
	input  wire logic                  CLK,
	input  wire logic                  RST,
	input  wire logic                  EXT_RESET_PIN,
	input  wire logic                  INT_RESET,
	input  wire logic                  POR_LVD,
	input  wire logic [1:0]            PWR_MODE,
	input  wire logic                  DSTB_RETURN,
	input  wire lpps_pkg::lpps_apb_req_t APB_REQ,
	output lpps_pkg::lpps_apb_rsp_t    APB_RSP,
	input  wire logic [NPINS-1:0]      PERIPH_OUT,
	input  wire logic [NPINS-1:0]      PERIPH_OE,
	input  wire logic [NPINS-1:0]      PORT_OUT,
	input  wire logic [NPINS-1:0]      PORT_OE,
	input  wire logic [NPINS-1:0]      PAD_IN,
	output logic [NPINS-1:0]           PAD_OUT,
	output logic [NPINS-1:0]           PAD_OE_N,
	output logic [NPINS-1:0]           CORE_IN,
	output logic [NPINS-1:0]           WAKE_IN,
	output logic [NPINS-1:0]           PORT_SEL,
	output logic [2:0]                 PSTATE
);
	import lpps_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [1:0]        rst_sync;
		logic [NPINS-1:0]  pad_s1;
		logic [NPINS-1:0]  pad_s2;
		lpps_pstate_t      pst;
		logic              stby_level;
		logic              osc_stop;
		logic [NPINS-1:0]  func_a;
		logic [NPINS-1:0]  func_b;
		logic [NPINS-1:0]  func_c;
		logic [NPINS-1:0]  fallb;
		logic [NPINS-1:0]  fb_active;
		logic [NPINS-1:0]  hold_out;
		logic [NPINS-1:0]  hold_oe;
		logic [NPINS-1:0]  pad_out;
		logic [NPINS-1:0]  pad_oe_n;
		logic [NPINS-1:0]  core_in;
		logic [NPINS-1:0]  wake_in;
		logic              pready;
		logic [31:0]       prdata;
		logic              pslverr;
	} lpps_state_t;

	lpps_state_t st_r;
	lpps_state_t st_nxt;

	// ****************************************
	// decode helpers
	// ****************************************
	function automatic lpps_func_t grp(input lpps_state_t s, input int i);
		return lpps_func_t'({s.func_c[i], s.func_b[i], s.func_a[i]});
	endfunction

	function automatic logic in_reset(input lpps_pstate_t p);
		return (p == PST_POR) || (p == PST_RSTIN) || (p == PST_IRST);
	endfunction

	function automatic logic is_low_power(input lpps_pstate_t p);
		return (p == PST_STOP) || (p == PST_DSTB);
	endfunction

	wire logic bus_acc = APB_REQ.psel && APB_REQ.penable;
	wire logic bus_wr  = bus_acc && APB_REQ.pwrite;
	wire logic bus_ok  = (APB_REQ.paddr == LPPS_OFF_CTRL) || (APB_REQ.paddr == LPPS_OFF_FUNC)
		|| (APB_REQ.paddr == LPPS_OFF_FALLB) || (APB_REQ.paddr == LPPS_OFF_STATUS)
		|| (APB_REQ.paddr == LPPS_OFF_FUNC_B);

	always_comb begin
		lpps_func_t g;
		logic       drive;
		logic       hiz;
		logic       gate;
		logic       wake;
		logic [31:0] rd;
		logic [2:0]  wf;
		g      = FN_GPIO;
		drive  = 1'b0;
		hiz    = 1'b0;
		gate   = 1'b0;
		wake   = 1'b0;
		rd     = LPPS_RST_ZERO;
		wf     = 3'h0;
		st_nxt = st_r;

		st_nxt.rst_sync = {st_r.rst_sync[0], EXT_RESET_PIN};
		st_nxt.pad_s1   = PAD_IN;
		st_nxt.pad_s2   = st_r.pad_s1;

		// ****************************************
		// power state selection
		// ****************************************
		if (POR_LVD)
			st_nxt.pst = PST_POR;
		else if (!st_r.rst_sync[1])
			st_nxt.pst = PST_RSTIN;
		else if (INT_RESET)
			st_nxt.pst = PST_IRST;
		else if (DSTB_RETURN)
			st_nxt.pst = PST_DRET;
		else if (PWR_MODE == 2'h2)
			st_nxt.pst = PST_DSTB;
		else if (PWR_MODE == 2'h1)
			st_nxt.pst = PST_STOP;
		else
			st_nxt.pst = PST_RUN;

		// ****************************************
		// apb slave, one wait state
		// ****************************************
		st_nxt.pready  = bus_acc && !st_r.pready;
		st_nxt.pslverr = bus_acc && !st_r.pready && !bus_ok;
		if (bus_acc && !st_r.pready && !APB_REQ.pwrite) begin
			case (APB_REQ.paddr)
				LPPS_OFF_CTRL:   rd = {30'h0, st_r.osc_stop, st_r.stby_level};
				LPPS_OFF_FUNC:   rd = {{(32-NPINS){1'b0}}, st_r.func_a};
				LPPS_OFF_FUNC_B: rd = {{(32-2*NPINS){1'b0}}, st_r.func_c, st_r.func_b};
				LPPS_OFF_FALLB:  rd = {{(32-NPINS){1'b0}}, st_r.fallb};
				LPPS_OFF_STATUS: rd = {{(29-NPINS){1'b0}}, st_r.fb_active, 3'(st_r.pst)};
				default:         rd = LPPS_RST_ZERO;
			endcase
		end
		st_nxt.prdata = rd;
		if (bus_wr && !st_r.pready) begin
			case (APB_REQ.paddr)
				LPPS_OFF_CTRL: begin
					st_nxt.stby_level = APB_REQ.pwdata[LPPS_CTRL_LEVEL];
					st_nxt.osc_stop = APB_REQ.pwdata[LPPS_CTRL_OSCST];
				end
				LPPS_OFF_FUNC, LPPS_OFF_FUNC_B: begin
					for (int i = 0; i < NPINS; i++) begin
						wf = {st_r.func_c[i], st_r.func_b[i], st_r.func_a[i]};
						if (APB_REQ.paddr == LPPS_OFF_FUNC)
							wf[0] = APB_REQ.pwdata[i];
						else
							wf[2:1] = {APB_REQ.pwdata[NPINS+i], APB_REQ.pwdata[i]};
						// locked entries refuse change while in reset
						if (!(in_reset(st_r.pst) && (grp(st_r, i) == FN_LOCKED
							|| lpps_func_t'(wf) == FN_LOCKED))) begin
							st_nxt.func_a[i] = wf[0];
							st_nxt.func_b[i] = wf[1];
							st_nxt.func_c[i] = wf[2];
						end
					end
				end
				LPPS_OFF_FALLB: st_nxt.fallb = APB_REQ.pwdata[NPINS-1:0];
				default: ;
			endcase
		end

		// ****************************************
		// per pin control
		// ****************************************
		for (int i = 0; i < NPINS; i++) begin
			g     = grp(st_r, i);
			drive = 1'b0;
			hiz   = 1'b0;
			gate  = 1'b0;
			wake  = 1'b0;
			if (st_r.pst == PST_DSTB && st_r.fallb[i])
				st_nxt.fb_active[i] = 1'b1;
			else if (st_r.pst == PST_RUN)
				st_nxt.fb_active[i] = st_r.fb_active[i] && !bus_wr;
			if (in_reset(st_r.pst)) begin
				hiz  = 1'b1;
				gate = (st_r.pst == PST_POR);
			end else if (g == FN_ANALOG) begin
				hiz  = 1'b1;
				gate = 1'b1;
			end else if (g == FN_XTAL_OUT && st_r.osc_stop && is_low_power(st_r.pst)) begin
				hiz  = 1'b1;
				gate = 1'b1;
			end else if (g == FN_WAKEUP
				&& (st_r.pst == PST_DSTB || st_r.pst == PST_DRET)) begin
				hiz  = 1'b1;
				wake = 1'b1;
			end else if (is_low_power(st_r.pst) && st_r.stby_level) begin
				hiz  = 1'b1;
				gate = 1'b1;
			end else if (st_r.pst == PST_RUN) begin
				drive = 1'b1;
			end else begin
				gate = is_low_power(st_r.pst) && (g == FN_GPIO || st_r.fb_active[i]);
				if (g == FN_PERIPH && !st_r.fb_active[i]) begin
					st_nxt.pad_out[i] = PERIPH_OUT[i];
					hiz = !PERIPH_OE[i];
				end else begin
					st_nxt.pad_out[i] = st_r.hold_out[i];
					hiz = !st_r.hold_oe[i];
				end
			end
			if (drive) begin
				st_nxt.hold_out[i] = (g == FN_PERIPH) ? PERIPH_OUT[i] : PORT_OUT[i];
				st_nxt.hold_oe[i]  = (g == FN_PERIPH) ? PERIPH_OE[i] : PORT_OE[i];
				st_nxt.pad_out[i]  = st_nxt.hold_out[i];
				hiz = !st_nxt.hold_oe[i];
			end
			if (hiz)
				st_nxt.pad_out[i] = 1'b0;
			st_nxt.pad_oe_n[i] = hiz;
			st_nxt.core_in[i]  = gate ? 1'b0 : st_r.pad_s2[i];
			st_nxt.wake_in[i]  = wake ? st_r.pad_s2[i] : 1'b0;
		end

		if (RST) begin
			st_nxt           = '0;
			st_nxt.pst       = PST_POR;
			st_nxt.pad_oe_n  = '1;
			st_nxt.func_a    = LPPS_PIN_FUNC[NPINS-1:0];
			st_nxt.fallb     = LPPS_PIN_FALLB[NPINS-1:0];
			st_nxt.rst_sync  = 2'h0; // reset-input until the pin proves high
		end
	end

	always_ff @(posedge CLK) begin
		st_r <= st_nxt;
	end

	assign APB_RSP.pready  = st_r.pready;
	assign APB_RSP.pslverr = st_r.pslverr;
	assign APB_RSP.prdata  = st_r.prdata;
	assign PAD_OUT  = st_r.pad_out;
	assign PAD_OE_N = st_r.pad_oe_n;
	assign CORE_IN  = st_r.core_in;
	assign WAKE_IN  = st_r.wake_in;
	assign PORT_SEL = st_r.fb_active;
	assign PSTATE   = 3'(st_r.pst);

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	a_reset_pin_state: assert property ($fell(st_r.rst_sync[1]) && !POR_LVD
		|=> st_r.pst == PST_RSTIN) else $error("reset pin low not seen");
	a_gate_zero: assert property (st_r.pst == PST_POR |=> CORE_IN == '0)
		else $error("gated input not zero");
	a_reset_hiz: assert property (in_reset(st_r.pst) |=> PAD_OE_N == '1)
		else $error("pad driven during reset");
	a_standby_hiz: assert property (st_r.pst == PST_STOP && st_r.stby_level
		&& !st_r.osc_stop && grp(st_r, 0) == FN_GPIO |=> PAD_OE_N[0] && !CORE_IN[0])
		else $error("standby level ignored");
	a_analog_off: assert property (st_r.pst == PST_RUN && grp(st_r, 3) == FN_ANALOG
		|=> PAD_OE_N[3] && !CORE_IN[3]) else $error("analog pin not isolated");
	a_port_hold: assert property (st_r.pst == PST_STOP && !st_r.stby_level
		&& grp(st_r, 0) == FN_GPIO |=> PAD_OE_N[0] == !$past(st_r.hold_oe[0])
		&& (PAD_OE_N[0] || PAD_OUT[0] == $past(st_r.hold_out[0])))
		else $error("port output not held");
	a_periph_follow: assert property (st_r.pst == PST_STOP && !st_r.stby_level
		&& grp(st_r, 1) == FN_PERIPH && !st_r.fb_active[1] && PERIPH_OE[1]
		|=> PAD_OUT[1] == $past(PERIPH_OUT[1]) && !PAD_OE_N[1])
		else $error("peripheral not followed");
	a_fallback_set: assert property (st_r.pst == PST_DSTB && st_r.fallb[1]
		|=> PORT_SEL[1]) else $error("fallback not taken");
	a_fallback_keep: assert property (st_r.pst == PST_DRET && st_r.fb_active[1]
		|=> PORT_SEL[1]) else $error("fallback lost on return");
	a_xtal_off: assert property (is_low_power(st_r.pst) && st_r.osc_stop
		&& grp(st_r, 2) == FN_XTAL_OUT |=> PAD_OE_N[2] && !CORE_IN[2])
		else $error("crystal pin not off");
	a_wake_path: assert property (st_r.pst == PST_DSTB && grp(st_r, 4) == FN_WAKEUP
		|=> PAD_OE_N[4] && WAKE_IN[4] == $past(st_r.pad_s2[4]))
		else $error("wake path wrong");
	a_wake_return: assert property (st_r.pst == PST_DRET && grp(st_r, 4) == FN_WAKEUP
		|=> PAD_OE_N[4] && WAKE_IN[4] == $past(st_r.pad_s2[4]))
		else $error("wake path lost on return");
	a_locked_keep: assert property (in_reset(st_r.pst) && grp(st_r, 5) == FN_LOCKED
		|=> grp(st_r, 5) == FN_LOCKED) else $error("locked function changed in reset");
	a_apb_answer: assert property (bus_acc && !st_r.pready |=> APB_RSP.pready)
		else $error("apb no answer");

	c_enter_dstb: cover property (st_r.pst == PST_RUN ##1 st_r.pst == PST_DSTB);
	c_return: cover property (st_r.pst == PST_DSTB ##1 st_r.pst == PST_DRET);
	c_standby_stop: cover property (st_r.pst == PST_STOP && st_r.stby_level);
	c_bad_addr: cover property (APB_RSP.pslverr);
	c_locked_write: cover property (in_reset(st_r.pst) && bus_wr && !st_r.pready);

endmodule

/* tb/lpps_periph_model.sv */
`timescale 1ns/10ps
module lpps_periph_model #(
	parameter int NPINS = 8
) (
	input  wire logic             clk,
	input  wire logic [NPINS-1:0] pad_oe_n,
	input  wire logic [NPINS-1:0] pad_out,
	input  wire logic             ext_lvl,
	output logic [NPINS-1:0]      periph_out,
	output logic [NPINS-1:0]      periph_oe,
	output logic [NPINS-1:0]      pad_in
);
	logic [NPINS-1:0] cnt_r = '0;

	// ****************************************
	// running peripheral, output moves every cycle
	// ****************************************
	always @(posedge clk) begin
		cnt_r <= cnt_r + 1'b1;
	end
	assign periph_out = cnt_r;
	assign periph_oe  = '1;

	// ****************************************
	// pad level: block drives it, else external source
	// ****************************************
	always_comb begin
		for (int i = 0; i < NPINS; i++) begin
			pad_in[i] = pad_oe_n[i] ? ext_lvl : pad_out[i];
		end
	end
endmodule

/* tb/low_power_pin_state_control_tb_top.sv */
`timescale 1ns/10ps
module low_power_pin_state_control_tb_top;
	import lpps_pkg::*;
	typedef struct {int i; logic [7:0] e; logic [7:0] m;} lpps_note_t;
	logic          clk;
	logic          rst;
	logic          ext_rst_n;
	logic          int_rst;
	logic          por;
	logic          dret;
	logic          ext_lvl;
	logic [1:0]    mode;
	lpps_apb_req_t req;
	lpps_apb_rsp_t rsp;
	logic [7:0]    per_out, per_oe, port_out, port_oe, pad_in;
	logic [7:0]    pad_out, pad_oe_n, core_in, wake_in, port_sel;
	logic [2:0]    pstate;
	logic [31:0]   seed = 32'h20;
	logic [31:0]   pv;
	logic [32:0]   apb_q[$];
	lpps_note_t    pin_q[$];
	lpps_note_t    nt;
	int            n_fail = 0;
	int            comparisons = 0;

	lpps_ctrl #(.NPINS(8)) u_dut (
		.CLK(clk), .RST(rst), .EXT_RESET_PIN(ext_rst_n), .INT_RESET(int_rst),
		.POR_LVD(por), .PWR_MODE(mode), .DSTB_RETURN(dret), .APB_REQ(req),
		.APB_RSP(rsp), .PERIPH_OUT(per_out), .PERIPH_OE(per_oe), .PORT_OUT(port_out),
		.PORT_OE(port_oe), .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE_N(pad_oe_n),
		.CORE_IN(core_in), .WAKE_IN(wake_in), .PORT_SEL(port_sel), .PSTATE(pstate)
	);
	lpps_periph_model #(.NPINS(8)) u_per (
		.clk(clk), .pad_oe_n(pad_oe_n), .pad_out(pad_out), .ext_lvl(ext_lvl),
		.periph_out(per_out), .periph_oe(per_oe), .pad_in(pad_in)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// ****************************************
	// compares, notes and bus cycles
	// ****************************************
	task automatic chk_apb(input logic [32:0] e, input logic [32:0] g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("Error t=%0t apb exp %h got %h", $time, e, g);
		end
	endtask
	task automatic chk_pin(input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("Error t=%0t pin exp %h got %h", $time, e, g);
		end
	endtask
	task automatic note(input int i, input logic [7:0] e, input logic [7:0] m);
		pin_q.push_back('{i, e & m, m});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			input logic [32:0] e);
		if (!w) apb_q.push_back(e);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (rsp.pready !== 1'b1);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ****************************************
	// result watchers
	// ****************************************
	always @(posedge clk) begin
		if (rsp.pready === 1'b1 && req.pwrite === 1'b0 && apb_q.size() > 0)
			chk_apb(apb_q.pop_front(), {rsp.pslverr, rsp.prdata});
	end
	always @(negedge clk) begin
		while (pin_q.size() > 0) begin
			nt = pin_q.pop_front();
			chk_pin(nt.e, {pstate, port_sel[nt.i], pad_oe_n[nt.i], pad_out[nt.i],
				core_in[nt.i], wake_in[nt.i]} & nt.m);
		end
	end
	initial begin
		cyc(3000);
		n_fail++;
		test_done();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rst = 1'b1;
		ext_rst_n = 1'b1;
		int_rst = 1'b0;
		por = 1'b0;
		dret = 1'b0;
		ext_lvl = 1'b1;
		mode = 2'd0;
		req = '0;
		port_out = '0;
		port_oe = '0;
		cyc(3);
		note(0, {3'd0, 5'b01000}, 8'hff);
		cyc(2);
		rst <= 1'b0;
		cyc(4);
		ext_rst_n <= 1'b0;
		cyc(5);
		note(0, {3'd1, 5'b01010}, 8'hfc);
		ext_rst_n <= 1'b1;
		cyc(5);
		note(0, {3'd3, 5'b00000}, 8'he0);
		$display("test reset_pin done");
		// pins: 0 port, 1 periph, 2 crystal, 3 analog, 4 wakeup, 5 locked
		apb(1'b1, LPPS_OFF_FUNC, 32'h0a, '0);
		apb(1'b1, LPPS_OFF_FUNC_B, 32'h302c, '0);
		apb(1'b1, LPPS_OFF_FALLB, 32'h02, '0);
		apb(1'b0, LPPS_OFF_FUNC, '0, {1'b0, 32'h0a});
		apb(1'b0, LPPS_OFF_FUNC_B, '0, {1'b0, 32'h302c});
		apb(1'b0, 12'h7fc, '0, {1'b1, 32'h0});
		apb(1'b0, LPPS_OFF_STATUS, '0, {1'b0, 32'h3});
		$display("test registers done");
		pv = xs();
		port_out <= pv[7:0];
		port_oe <= 8'hff;
		cyc(4);
		note(3, {3'd3, 5'b01000}, 8'hff);
		note(1, {3'd3, 5'b00000}, 8'hf8);
		mode <= 2'd1;
		cyc(4);
		port_out <= ~pv[7:0];
		cyc(4);
		note(0, {3'd4, 2'b00, pv[0], 2'b00}, 8'hfd);
		note(1, {3'd4, 5'b00000}, 8'hf8);
		note(3, {3'd4, 5'b01000}, 8'hff);
		apb(1'b1, LPPS_OFF_CTRL, 32'h2, '0);
		cyc(3);
		note(2, {3'd4, 5'b01000}, 8'hff);
		apb(1'b0, LPPS_OFF_CTRL, '0, {1'b0, 32'h2});
		apb(1'b1, LPPS_OFF_CTRL, 32'h1, '0);
		cyc(3);
		note(0, {3'd4, 5'b01000}, 8'hff);
		$display("test stop done");
		apb(1'b1, LPPS_OFF_CTRL, 32'h0, '0);
		mode <= 2'd2;
		cyc(6);
		note(4, {3'd5, 5'b01001}, 8'hfd);
		note(1, {3'd5, 5'b10000}, 8'hf0);
		mode <= 2'd0;
		dret <= 1'b1;
		cyc(4);
		note(4, {3'd6, 5'b01001}, 8'hfd);
		note(1, {3'd6, 5'b10000}, 8'hf0);
		dret <= 1'b0;
		cyc(4);
		note(1, {3'd3, 5'b10000}, 8'hf0);
		apb(1'b1, LPPS_OFF_CTRL, 32'h0, '0);
		cyc(3);
		note(1, {3'd3, 5'b00000}, 8'hf0);
		$display("test deep_standby done");
		int_rst <= 1'b1;
		cyc(3);
		apb(1'b1, LPPS_OFF_FUNC_B, 32'h100c, '0);
		apb(1'b0, LPPS_OFF_FUNC_B, '0, {1'b0, 32'h302c});
		note(5, {3'd2, 5'b01010}, 8'hfc);
		por <= 1'b1;
		cyc(3);
		note(0, {3'd0, 5'b01000}, 8'hff);
		por <= 1'b0;
		int_rst <= 1'b0;
		cyc(4);
		apb(1'b1, LPPS_OFF_FUNC_B, 32'h100c, '0);
		apb(1'b0, LPPS_OFF_FUNC_B, '0, {1'b0, 32'h100c});
		cyc(2);
		$display("test locked done");
		test_done();
	end
endmodule
